// >>> hdl/via_pkg.sv
package via_pkg;
  // Register offsets on the plain register port
  localparam logic [7:0] VIA_OFS_VECTOR  = 8'h00;
  localparam logic [7:0] VIA_OFS_STD_EN  = 8'h01;
  localparam logic [7:0] VIA_OFS_MCU_CFG = 8'h02;

  // Values after reset
  localparam logic [7:0] VIA_VECTOR_RST  = 8'h00;
  localparam logic [7:0] VIA_STD_EN_RST  = 8'h00;
  localparam logic [7:0] VIA_MCU_CFG_RST = 8'h00;
  localparam logic [7:0] VIA_RDATA_RST   = 8'h00;

  // Standard enable register fields
  localparam int         VIA_EN_LINE0    = 0;
  localparam int         VIA_EN_TIMER0   = 1;
  localparam int         VIA_EN_LINE1    = 2;
  localparam int         VIA_EN_TIMER1   = 3;
  localparam int         VIA_EN_SERIAL   = 4;
  localparam int         VIA_EN_GLOBAL   = 7;
  localparam logic [7:0] VIA_STD_EN_MASK = 8'h9f;

  // Configuration register field: line one source select
  localparam int         VIA_CFG_LINE1_SEL = 0;

  // Vector layout
  localparam int         VIA_IDX_LSB   = 1;
  localparam int         VIA_GRP_LSB   = 4;
  localparam int         VIA_FIRST_GRP = 1;
  localparam int         VIA_GRP_SLOTS = 8;

  // Core entry addresses
  localparam logic [15:0] VIA_ENTRY_RESET  = 16'h0000;
  localparam logic [15:0] VIA_ENTRY_LINE0  = 16'h0003;
  localparam logic [15:0] VIA_ENTRY_TIMER0 = 16'h000b;
  localparam logic [15:0] VIA_ENTRY_LINE1  = 16'h0013;
  localparam logic [15:0] VIA_ENTRY_TIMER1 = 16'h001b;
  localparam logic [15:0] VIA_ENTRY_SERIAL = 16'h0023;

  // Core interrupt sources in fixed core priority order
  typedef enum logic [2:0] {
    VIA_SRC_LINE0,
    VIA_SRC_TIMER0,
    VIA_SRC_LINE1,
    VIA_SRC_TIMER1,
    VIA_SRC_SERIAL
  } via_core_src_t;
endpackage

// >>> hdl/via_aggregator.sv
// What this block does
// - Any pending peripheral source drives the single level request on line zero.
// - Vector register holds the source code that trapped to entry 0003.
// - Any write to vector retires it and loads the next pending vector.
// - Vector bit 0 always reads zero; codes step by two.
// - Vector reads zero while nothing is pending.
// - Index in bits 3..1, group in bits 7..4, both reset to zero.
// - First come first served within a group; group 4 beats group 1.
// - Fixed hardware priority by group, group 4 highest, group 1 lowest.
// - Priority encoder yields an 8-bit vector covering 32 possible sources.
// - Groups 1 and 2 indices 1..3 are output and input endpoints 1..3.
// - Group 3 holds seven bus events, group 4 holds I2C and endpoint 0.
// - Active-low output mirrors the peripheral request to an external controller.
// - Port-2 active-low inputs are ORed into edge-triggered line one.
// - Line one also feeds the suspend and resume logic for wake-up.
// - Config select bit picks port-3 bit-3 pin (0) or port 2 (1).
// - Global gate bit 7 blocks all five core requests when clear.
// - Enable bits 0..4 read/write, bits 5..6 read zero, reset zero.
// - Core entries: 0000, 0003, 000B, 0013, 001B, 0023.
`timescale 1ns/1ns
module via_aggregator #(
  parameter int NUM_GRP = 4
) (
  // Clock, reset, enable
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        clkEn,
  // Register port
  input  wire logic [7:0]  regAddr,
  input  wire logic [7:0]  regWrData,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic      [7:0]  regRdData,
  // Peripheral event pulses
  input  wire logic [2:0]  outEpEvt,
  input  wire logic [2:0]  inEpEvt,
  input  wire logic [6:0]  busEvt,
  input  wire logic [3:0]  grp4Evt,
  // Pins, active low
  input  wire logic [7:0]  port2In_n,
  input  wire logic        port3Bit3_n,
  // Standard core sources and core acknowledge
  input  wire logic        timer0Irq,
  input  wire logic        timer1Irq,
  input  wire logic        serialIrq,
  input  wire logic        coreAck,
  // Core side outputs
  output logic             coreIrqReq,
  output via_pkg::via_core_src_t coreSrc,
  output logic      [15:0] coreEntryAddr,
  output logic             periphIrqLineZero_n,
  output logic             portIrqLineOne_n,
  output logic             lineOneWake,
  output logic             externalHostIrqOut_n
);
  import via_pkg::*;

  localparam int NSLOT  = NUM_GRP * VIA_GRP_SLOTS;
  localparam int SLOT_W = $clog2(NSLOT);

  // Slot number of a nonzero vector
  function automatic logic [SLOT_W-1:0] slotOf(input logic [7:0] v);
    logic [7:0] s;
    s = {1'b0, v[7:VIA_GRP_LSB] - 4'(VIA_FIRST_GRP), v[VIA_GRP_LSB-1:VIA_IDX_LSB]};
    return s[SLOT_W-1:0];
  endfunction

  // Highest group with any pending slot, zero when none
  function automatic logic [3:0] topGroup(input logic [NSLOT-1:0] p);
    logic [3:0] g;
    g = 4'h0;
    for (int k = 0; k < NSLOT; k++) begin
      if (p[k]) begin
        g = 4'(k / VIA_GRP_SLOTS + VIA_FIRST_GRP);
      end
    end
    return g;
  endfunction

  // Entry address of a core source
  function automatic logic [15:0] entryOf(input via_core_src_t s);
    case (s)
      VIA_SRC_LINE0:  return VIA_ENTRY_LINE0;
      VIA_SRC_TIMER0: return VIA_ENTRY_TIMER0;
      VIA_SRC_LINE1:  return VIA_ENTRY_LINE1;
      VIA_SRC_TIMER1: return VIA_ENTRY_TIMER1;
      VIA_SRC_SERIAL: return VIA_ENTRY_SERIAL;
      default:        return VIA_ENTRY_RESET;
    endcase
  endfunction

  logic [7:0]       vec;
  logic [7:0]       stdEn;
  logic [7:0]       mcuCfg;
  logic [NSLOT-1:0] pend;
  logic [2:0]       rank [NSLOT];
  logic [2:0]       next_rank [NSLOT];
  logic [7:0]       next_vec;
  logic [NSLOT-1:0] srcSet;
  logic [NSLOT-1:0] retire;
  logic [NSLOT-1:0] alive;
  logic [NSLOT-1:0] next_pend;
  logic             vecWr;
  logic             stdEnWr;
  logic             cfgWr;
  logic             vecBusy;
  logic             vecLoad;
  logic             line0Act;
  logic [SLOT_W-1:0] curSlot;
  logic [7:0]       p2Meta;
  logic [7:0]       p2Sync;
  logic             p33Meta;
  logic             p33Sync;
  logic             line1Act;
  logic             line1Q;
  logic             line1Flag;
  logic [4:0]       coreReq;
  logic [2:0]       retRank;
  logic             retHit;
  logic [3:0]       cnt;
  logic [7:0]       rdMux;
  via_core_src_t    next_src;

  // Source map: group 1 output endpoints, group 2 input endpoints,
  // group 3 bus events, group 4 I2C and endpoint 0; holes never set
  assign srcSet = NSLOT'({4'h0, grp4Evt, 1'b0, busEvt,
                          4'h0, inEpEvt, 1'b0, 4'h0, outEpEvt, 1'b0});

  // Register decode
  assign vecWr   = regWr && (regAddr == VIA_OFS_VECTOR);
  assign stdEnWr = regWr && (regAddr == VIA_OFS_STD_EN);
  assign cfgWr   = regWr && (regAddr == VIA_OFS_MCU_CFG);

  // Retire the presented source on any vector write; an arrival in the
  // same cycle re-queues it, so the event is never lost
  assign vecBusy   = vec != 8'h00;
  assign curSlot   = slotOf(vec);
  assign retire    = (vecBusy && vecWr) ? (NSLOT'(1) << curSlot) : '0;
  assign alive     = pend & ~retire;
  assign next_pend = alive | srcSet;
  assign vecLoad   = !vecBusy || vecWr;

  // Arrival order per group: ranks stay dense, a retired entry
  // pulls later ones forward, new ones join at the tail
  always_comb begin
    retRank = 3'h0;
    retHit  = 1'b0;
    cnt     = 4'h0;
    for (int s = 0; s < NSLOT; s++) begin
      next_rank[s] = rank[s];
    end
    for (int g = 0; g < NUM_GRP; g++) begin
      retRank = 3'h0;
      retHit  = 1'b0;
      cnt     = 4'h0;
      for (int i = 0; i < VIA_GRP_SLOTS; i++) begin
        if (retire[g*VIA_GRP_SLOTS+i]) begin
          retHit  = 1'b1;
          retRank = rank[g*VIA_GRP_SLOTS+i];
        end
        cnt = cnt + 4'(alive[g*VIA_GRP_SLOTS+i]);
      end
      for (int i = 0; i < VIA_GRP_SLOTS; i++) begin
        if (alive[g*VIA_GRP_SLOTS+i]) begin
          if (retHit && rank[g*VIA_GRP_SLOTS+i] > retRank) begin
            next_rank[g*VIA_GRP_SLOTS+i] = rank[g*VIA_GRP_SLOTS+i] - 3'h1;
          end
        end else if (srcSet[g*VIA_GRP_SLOTS+i]) begin
          next_rank[g*VIA_GRP_SLOTS+i] = cnt[2:0];
          cnt = cnt + 4'h1;
        end
      end
    end
  end

  // Priority encoder: oldest entry per group, later groups override
  // so the highest group wins; empty gives vector zero
  always_comb begin
    next_vec = 8'h00;
    for (int g = 0; g < NUM_GRP; g++) begin
      for (int i = 0; i < VIA_GRP_SLOTS; i++) begin
        if (next_pend[g*VIA_GRP_SLOTS+i] && next_rank[g*VIA_GRP_SLOTS+i] == 3'h0) begin
          next_vec = {4'(g + VIA_FIRST_GRP), 3'(i), 1'b0};
        end
      end
    end
  end

  // Pending flags, ranks and vector; vector holds until written
  always_ff @(posedge clk) begin
    if (rst) begin
      pend <= '0;
      vec  <= VIA_VECTOR_RST;
      for (int s = 0; s < NSLOT; s++) begin
        rank[s] <= 3'h0;
      end
    end else if (clkEn) begin
      pend <= next_pend;
      rank <= next_rank;
      if (vecLoad) begin
        vec <= next_vec;
      end
    end
  end

  // Enable and configuration registers
  always_ff @(posedge clk) begin
    if (rst) begin
      stdEn  <= VIA_STD_EN_RST;
      mcuCfg <= VIA_MCU_CFG_RST;
    end else if (clkEn) begin
      if (stdEnWr) begin
        stdEn <= regWrData & VIA_STD_EN_MASK;
      end
      if (cfgWr) begin
        mcuCfg <= {7'h00, regWrData[VIA_CFG_LINE1_SEL]};
      end
    end
  end

  // Read data one cycle after the strobe; unmapped reads give zero
  always_comb begin
    case (regAddr)
      VIA_OFS_VECTOR:  rdMux = vec;
      VIA_OFS_STD_EN:  rdMux = stdEn;
      VIA_OFS_MCU_CFG: rdMux = mcuCfg;
      default:         rdMux = 8'h00;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      regRdData <= VIA_RDATA_RST;
    end else if (clkEn && regRd) begin
      regRdData <= rdMux;
    end
  end

  // Pin synchronisers; idle level is high on active-low pins
  always_ff @(posedge clk) begin
    if (rst) begin
      p2Meta  <= 8'hff;
      p2Sync  <= 8'hff;
      p33Meta <= 1'b1;
      p33Sync <= 1'b1;
    end else if (clkEn) begin
      p2Meta  <= port2In_n;
      p2Sync  <= p2Meta;
      p33Meta <= port3Bit3_n;
      p33Sync <= p33Meta;
    end
  end

  // Line one source: any low port-2 input when select is set, else the port-3 pin
  assign line1Act = mcuCfg[VIA_CFG_LINE1_SEL] ? !(&p2Sync) : !p33Sync;

  // Peripheral request: pending entries or a vector still shown
  assign line0Act = (|pend) || vecBusy;

  // Edge flag for line one; a new edge beats a same-cycle acknowledge
  always_ff @(posedge clk) begin
    if (rst) begin
      line1Q    <= 1'b0;
      line1Flag <= 1'b0;
    end else if (clkEn) begin
      line1Q <= line1Act;
      if (line1Act && !line1Q) begin
        line1Flag <= 1'b1;
      end else if (coreAck && coreSrc == VIA_SRC_LINE1) begin
        line1Flag <= 1'b0;
      end
    end
  end

  // Core requests gated by own enables and the global gate
  assign coreReq = {serialIrq, timer1Irq, line1Flag, timer0Irq, line0Act}
                 & stdEn[VIA_EN_SERIAL:VIA_EN_LINE0]
                 & {5{stdEn[VIA_EN_GLOBAL]}};

  // Lowest index wins, as the standard core orders its sources
  always_comb begin
    next_src = VIA_SRC_SERIAL;
    for (int k = 4; k >= 0; k--) begin
      if (coreReq[k]) begin
        next_src = via_core_src_t'(3'(k));
      end
    end
  end

  // Registered core and pin outputs
  always_ff @(posedge clk) begin
    if (rst) begin
      coreIrqReq           <= 1'b0;
      coreSrc              <= VIA_SRC_LINE0;
      coreEntryAddr        <= VIA_ENTRY_RESET;
      periphIrqLineZero_n  <= 1'b1;
      externalHostIrqOut_n <= 1'b1;
      portIrqLineOne_n     <= 1'b1;
      lineOneWake          <= 1'b0;
    end else if (clkEn) begin
      coreIrqReq           <= |coreReq;
      coreSrc              <= next_src;
      coreEntryAddr        <= entryOf(next_src);
      periphIrqLineZero_n  <= !line0Act;
      externalHostIrqOut_n <= !line0Act;
      portIrqLineOne_n     <= !line1Act;
      lineOneWake          <= line1Act;
    end
  end

  // Checks
  default clocking cb @(posedge clk); endclocking

  // Highest pending group, a plain signal so the checks can look back on it
  logic [3:0]       topGrp;
  assign topGrp = topGroup(pend);
  default disable iff (rst || !clkEn);

  sequence s_retire;
    vecBusy && vecWr && !srcSet[curSlot];
  endsequence

  sequence s_line1Edge;
    line1Act && !line1Q;
  endsequence

  sequence s_idleLoad;
    !vecBusy && (|pend);
  endsequence

  line0_held_a: assert property (vecBusy |=> !periphIrqLineZero_n)
    else $error("line zero released while vector shown");
  vec_even_a: assert property (!vec[0])
    else $error("vector bit 0 set");
  vec_hold_a: assert property (vecBusy && !vecWr |=> $stable(vec))
    else $error("vector changed without a write");
  vec_idle_a: assert property (!vecBusy && pend == '0 && srcSet == '0 |=> vec == 8'h00)
    else $error("vector nonzero with nothing pending");
  retire_slot_a: assert property (s_retire |=> !pend[$past(curSlot)])
    else $error("written vector not retired");
  load_next_a: assert property (s_idleLoad |=> vecBusy)
    else $error("pending source not presented");
  group_prio_a: assert property (s_idleLoad |=> vec[7:4] >= $past(topGrp))
    else $error("lower group presented first");
  std_rsv_a: assert property (stdEn[6:5] == 2'b00)
    else $error("reserved enable bits set");
  global_gate_a: assert property (!stdEn[VIA_EN_GLOBAL] |=> !coreIrqReq)
    else $error("request passed with global gate clear");
  line1_edge_a: assert property (s_line1Edge |=> line1Flag && !portIrqLineOne_n)
    else $error("line one edge lost");
  ext_mirror_a: assert property ((|pend) |=> !externalHostIrqOut_n && !periphIrqLineZero_n)
    else $error("external line not driven for a pending source");

  // Register port and core side checks; the enable write is masked
  // so that software can never set the reserved bits
  std_en_wr_a: assert property (stdEnWr |=>
    stdEn == ($past(regWrData) & VIA_STD_EN_MASK))
    else $error("enable write not taken");
  rd_vec_a: assert property (regRd && regAddr == VIA_OFS_VECTOR |=>
    regRdData == $past(vec))
    else $error("vector read returned wrong data");
  ack_clear_a: assert property (coreAck && coreSrc == VIA_SRC_LINE1 && line1Q |=>
    !line1Flag)
    else $error("line one flag not cleared by acknowledge");
  line1_wake_a: assert property (line1Act |=> lineOneWake && !portIrqLineOne_n)
    else $error("wake line does not follow line one");
  entry_map_a: assert property (coreIrqReq |-> coreEntryAddr == entryOf(coreSrc))
    else $error("entry address does not match source");
  line0_first_a: assert property (coreReq[VIA_EN_LINE0] |=> coreSrc == VIA_SRC_LINE0)
    else $error("line zero not served first");
endmodule

// >>> testbench/via_core_model.sv
`timescale 1ns/1ns
module via_core_model (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Acknowledge behaviour
  input  wire logic       ackOn,
  input  wire logic [3:0] ackDelay,
  // Core request side
  input  wire logic       coreIrqReq,
  output logic            coreAck
);
  logic [3:0] waitCnt;

  // Ack after a set wait; a slow core just waits longer, never acks idle
  always_ff @(posedge clk) begin
    if (rst || !coreIrqReq || !ackOn || coreAck) begin
      waitCnt <= 4'h0;
      coreAck <= 1'b0;
    end else if (waitCnt == ackDelay) begin
      coreAck <= 1'b1;
    end else begin
      waitCnt <= waitCnt + 4'h1;
    end
  end
endmodule

// >>> testbench/vectored_interrupt_aggregator_tb.sv
`timescale 1ns/1ns
module vectored_interrupt_aggregator_tb;
  import via_pkg::*;
  logic          clk = 1'b0;
  logic          rst, clkEn, regWr, regRd, coreAck, ackOn;
  logic          timer0Irq, timer1Irq, serialIrq, port3Bit3_n;
  logic [7:0]    regAddr, regWrData, regRdData, port2In_n, d;
  logic [16:0]   evt;
  logic [3:0]    ackDelay;
  logic          coreIrqReq, lineZero_n, lineOne_n, lineOneWake, extIrq_n;
  logic [15:0]   entry;
  via_core_src_t coreSrc;
  int            num_errors = 0;
  int            n_compared = 0;

  // 20 MHz clock
  always #25 clk = ~clk;

  via_aggregator #(.NUM_GRP(4)) uut (
    .clk(clk), .rst(rst), .clkEn(clkEn),
    .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
    .regRdData(regRdData), .outEpEvt(evt[2:0]), .inEpEvt(evt[5:3]),
    .busEvt(evt[12:6]), .grp4Evt(evt[16:13]), .port2In_n(port2In_n),
    .port3Bit3_n(port3Bit3_n), .timer0Irq(timer0Irq), .timer1Irq(timer1Irq),
    .serialIrq(serialIrq), .coreAck(coreAck), .coreIrqReq(coreIrqReq),
    .coreSrc(coreSrc), .coreEntryAddr(entry), .periphIrqLineZero_n(lineZero_n),
    .portIrqLineOne_n(lineOne_n), .lineOneWake(lineOneWake),
    .externalHostIrqOut_n(extIrq_n));

  via_core_model core (
    .clk(clk), .rst(rst), .ackOn(ackOn), .ackDelay(ackDelay),
    .coreIrqReq(coreIrqReq), .coreAck(coreAck));

  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("Error t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask

  // Bus cycles: one strobe cycle, read data sampled mid-cycle after
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    regAddr <= a;
    regWrData <= v;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    @(negedge clk);
    v = regRdData;
  endtask

  task automatic pulse(input logic [16:0] m);
    @(posedge clk);
    evt <= m;
    @(posedge clk);
    evt <= '0;
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask

  // Bounded wait for line one to reach a level
  task automatic waitLine(input logic v);
    for (int k = 0; k < 12; k++) begin
      @(negedge clk);
      if (lineOne_n === v) return;
    end
    chk({15'h0, v}, {15'h0, lineOne_n});
    test_done();
  endtask

  // Read and retire vectors in turn, expecting s[0..n-1]
  task automatic drain(input logic [7:0] s [5], input int n);
    for (int k = 0; k < n; k++) begin
      rd(VIA_OFS_VECTOR, d);
      chk({8'h00, s[k]}, {8'h00, d});
      wr(VIA_OFS_VECTOR, 8'h00);
    end
  endtask

  task automatic t_regs();
    rd(VIA_OFS_VECTOR, d);
    chk(16'h0000, {8'h00, d});
    rd(VIA_OFS_STD_EN, d);
    chk(16'h0000, {8'h00, d});
    wr(VIA_OFS_STD_EN, 8'hff);
    rd(VIA_OFS_STD_EN, d);
    chk(16'h009f, {8'h00, d});
    wr(VIA_OFS_MCU_CFG, 8'h01);
    rd(VIA_OFS_MCU_CFG, d);
    chk(16'h0001, {8'h00, d});
    wr(VIA_OFS_STD_EN, 8'h00);
    rd(8'h03, d);
    chk(16'h0000, {8'h00, d});
    wr(VIA_OFS_VECTOR, 8'h5b);
    rd(VIA_OFS_VECTOR, d);
    chk(16'h0000, {8'h00, d});
    $display("registers done");
  endtask

  // A write while the clock enable is low must leave no trace
  task automatic t_freeze();
    @(posedge clk);
    clkEn <= 1'b0;
    wr(VIA_OFS_STD_EN, 8'h9f);
    @(posedge clk);
    clkEn <= 1'b1;
    rd(VIA_OFS_STD_EN, d);
    chk(16'h0000, {8'h00, d});
    $display("clock enable done");
  endtask

  // Every assigned source alone, code from group and index
  task automatic t_table();
    logic [7:0] e;
    for (int i = 0; i < 17; i++) begin
      e = (i < 3) ? 8'h12 + 8'(2*i) : (i < 6) ? 8'h22 + 8'(2*i-6) :
          (i < 13) ? 8'h30 + 8'(2*i-12) : 8'h40 + 8'(2*i-26);
      pulse(17'h1 << i);
      rd(VIA_OFS_VECTOR, d);
      chk({8'h00, e}, {8'h00, d});
      chk(16'h0000, {15'h0, lineZero_n});
      chk(16'h0000, {15'h0, extIrq_n});
      wr(VIA_OFS_VECTOR, 8'hff);
      rd(VIA_OFS_VECTOR, d);
      chk(16'h0000, {8'h00, d});
      chk(16'h0001, {15'h0, lineZero_n});
    end
    $display("vector table done");
  endtask

  // Groups outrank; inside a group the earlier arrival wins
  task automatic t_order();
    pulse(17'h00001);
    pulse(17'h10060);
    drain('{8'h12, 8'h46, 8'h30, 8'h26, 8'h00}, 5);
    pulse(17'h02000);
    pulse(17'h00800);
    pulse(17'h00080);
    drain('{8'h40, 8'h3a, 8'h32, 8'h00, 8'h00}, 4);
    $display("priority done");
  endtask

  task automatic t_line_one();
    wr(VIA_OFS_MCU_CFG, 8'h01);
    wr(VIA_OFS_STD_EN, 8'h84);
    ackDelay <= 4'h5;
    port3Bit3_n <= 1'b0;
    settle(8);
    chk(16'h0001, {15'h0, lineOne_n});
    @(posedge clk);
    port3Bit3_n <= 1'b1;
    port2In_n <= 8'hf7;
    waitLine(1'b0);
    chk(16'h0001, {15'h0, lineOneWake});
    settle(3);
    chk(16'h0001, {15'h0, coreIrqReq});
    chk(16'h0013, entry);
    chk(16'h0002, 16'(coreSrc));
    @(posedge clk);
    ackOn <= 1'b1;
    settle(10);
    chk(16'h0000, {15'h0, coreIrqReq});
    chk(16'h0000, {15'h0, lineOne_n});
    @(posedge clk);
    port2In_n <= 8'hff;
    wr(VIA_OFS_MCU_CFG, 8'h00);
    waitLine(1'b1);
    @(posedge clk);
    port3Bit3_n <= 1'b0;
    waitLine(1'b0);
    @(posedge clk);
    port3Bit3_n <= 1'b1;
    waitLine(1'b1);
    settle(8);
    chk(16'h0000, {15'h0, coreIrqReq});
    @(posedge clk);
    ackOn <= 1'b0;
    $display("line one done");
  endtask

  task automatic t_gate();
    wr(VIA_OFS_STD_EN, 8'h02);
    timer0Irq <= 1'b1;
    settle(4);
    chk(16'h0000, {15'h0, coreIrqReq});
    wr(VIA_OFS_STD_EN, 8'h82);
    settle(3);
    chk(16'h000b, entry);
    @(posedge clk);
    timer0Irq <= 1'b0;
    timer1Irq <= 1'b1;
    serialIrq <= 1'b1;
    wr(VIA_OFS_STD_EN, 8'h98);
    settle(3);
    chk(16'h001b, entry);
    wr(VIA_OFS_STD_EN, 8'h90);
    settle(3);
    chk(16'h0023, entry);
    @(posedge clk);
    timer1Irq <= 1'b0;
    serialIrq <= 1'b0;
    wr(VIA_OFS_STD_EN, 8'h81);
    pulse(17'h00004);
    settle(3);
    chk(16'h0003, entry);
    wr(VIA_OFS_VECTOR, 8'h00);
    $display("core gating done");
  endtask

  // Watchdog against a hung run
  initial begin
    #2000000;
    num_errors++;
    $display("Error t=%0t watchdog expired", $time);
    test_done();
  end

  initial begin
    rst = 1'b1;
    clkEn = 1'b1;
    {regWr, regRd, ackOn, timer0Irq, timer1Irq, serialIrq} = '0;
    {regAddr, regWrData, evt, ackDelay} = '0;
    port2In_n = 8'hff;
    port3Bit3_n = 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_freeze();
    t_table();
    t_order();
    t_line_one();
    t_gate();
    test_done();
  end
endmodule
